// ---- autoneg_next_page_regs.sv ----
// APB register bank for auto-negotiation expansion status and next pages
//
// Function
// - Expansion status at 6h, resets 0004h, high bits zero
// - Bit 4 flags a parallel detection fault
// - Bit 3 shows partner next-page ability
// - Bit 2 read-only local next-page ability, one
// - Bit 1 flags a newly received page
// - Bit 0 shows partner auto-negotiation ability
// - Transmit next page at 7h, resets 2001h
// - Bit 13 selects message or unformatted code
// - Code resets to null message page
// - Toggle inverts previous exchanged word's toggle
// - Received next page at 8h, read-only
// - Bit 14 shows partner acknowledge
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module autoneg_next_page_regs
  import autoneg_np_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  // APB slave side
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [DATA_W-1:0] pwdata_in,
  input  wire logic [3:0]        pstrb_in,
  output var  logic [DATA_W-1:0] prdata_out,
  output var  logic              pready_out,
  output var  logic              pslverr_out,
  output var  logic              irq_out,
  // Link events and partner levels
  input  wire logic              pd_fault_in,
  input  wire logic              page_rx_in,
  input  wire logic [15:0]       rx_page_in,
  input  wire logic              lp_np_able_in,
  input  wire logic              lp_an_able_in,
  input  wire logic              an_restart_in,
  // Outgoing next page
  output var  logic [15:0]       tx_page_out
);

  // Register map, byte address four times the index
  //   0x018 expansion status, flags clear on read
  //   0x01c transmit next page, software copy
  //   0x020 received next page, read-only
  //   0x040 interrupt status, write one to clear
  //   0x044 interrupt mask, same layout as status
  // Other addresses answer with an error
  // Misaligned or high address bits also error
  // Writes to read-only registers dropped quietly
  //
  // Bus answer timing
  //   Setup edge: read data and error captured
  //   Access edge: write lands, read flags clear
  //   Zero wait states on every transfer
  //   Read data stands until the next setup
  //   Back-to-back transfers accepted
  //
  // Read-clear hazard
  //   Only flags that were returned are cleared
  //   Event at the access edge survives the clear
  //   Event after the setup edge shows next read
  //
  // Event timing
  //   Event edge: flags, toggle and page captured
  //   Next edge: page pins and interrupt follow
  //   Restart pulse forces the toggle low
  //   Restart beats a page for the toggle
  //
  // Transmit page assembly
  //   Bit 15 next page, from software
  //   Bit 14 always low on the wire
  //   Bit 13 message or unformatted code
  //   Bit 12 comply indication, from software
  //   Bit 11 toggle, from the exchange tracker
  //   Bits 10 to 0 code, null message after reset
  //
  // Interrupt
  //   Status bit 0 page received, bit 1 fault
  //   Level output, one cycle behind status
  //   Mask resets to all events blocked
  //
  // Byte strobes
  //   Lanes 0 and 1 reach the 16-bit registers
  //   Lane 0 alone gates the interrupt registers
  //   Lanes 2 and 3 have no effect
  //
  // Limitations
  //   Partner ability bits are read live
  //   Inputs assumed synchronous to the clock
  //   Event inputs are single-cycle pulses
  //   A held event input keeps its flag set
  //
  // Reset state
  //   Bus answer idle, no error, data zero
  //   Transmit page 2001h, toggle low
  //   Received page zero, all flags clear
  //
  // Read data upper half always zero
  // Reserved bits of expansion read zero
  // Local next-page ability fixed high
  //
  // Sticky flag banks
  //   Expansion copy clears on read
  //   Interrupt copy clears on write of one
  //   Both banks see the same events

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
    logic [REG_W-1:0]  np_tx;
    logic [N_EVT-1:0]  irq_mask;
    logic              irq;
    logic [REG_W-1:0]  tx_page;
  } regs_state_s;

  regs_state_s cur_r;
  regs_state_s cur_nxt;

  // Sticky flags of the expansion register and of the interrupt status
  flag_if #(.W(N_EVT)) exp_flags ();
  flag_if #(.W(N_EVT)) irq_flags ();

  logic              toggle;
  logic [REG_W-1:0]  rx_page;

  // Decoded transfer phases
  logic              setup_phase;
  logic              access_done;
  logic              wr_done;
  logic              rd_done;
  logic [7:0]        reg_idx;
  logic              aligned;
  logic              mapped;
  logic [REG_W-1:0]  lane_mask;
  logic [REG_W-1:0]  exp_word;
  logic [DATA_W-1:0] rd_word;
  logic [N_EVT-1:0]  exp_clr;
  logic [N_EVT-1:0]  irq_clr;
  logic [N_EVT-1:0]  events;

  // Expansion event flags, cleared by reading
  sticky_flags #(.W(N_EVT)) u_exp_flags
  (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .flags      (exp_flags.owner)
  );

  // Interrupt status flags, cleared by writing a one
  sticky_flags #(.W(N_EVT)) u_irq_flags
  (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .flags      (irq_flags.owner)
  );

  // Toggle and partner page tracking
  np_exchange u_np_exchange
  (
    .sys_clk_in  (sys_clk_in),
    .rst_n_in    (rst_n_in),
    .page_rx_in  (page_rx_in),
    .rx_page_in  (rx_page_in),
    .restart_in  (an_restart_in),
    .toggle_out  (toggle),
    .rx_page_out (rx_page)
  );

  // Event vector in flag order
  always_comb
  begin
    events               = '0;
    events[EVT_PAGE_RX]  = page_rx_in;
    events[EVT_PD_FAULT] = pd_fault_in;
  end

  // Both flag banks see the same events
  assign exp_flags.set = events;
  assign irq_flags.set = events;
  assign exp_flags.clr = exp_clr;
  assign irq_flags.clr = irq_clr;

  // APB phase decode
  assign setup_phase = psel_in & ~penable_in;
  assign access_done = psel_in & penable_in & cur_r.pready;
  assign wr_done     = access_done & pwrite_in & ~cur_r.pslverr;
  assign rd_done     = access_done & ~pwrite_in & ~cur_r.pslverr;
  assign reg_idx     = paddr_in[9:2];
  assign aligned     = (paddr_in[1:0] == 2'h0) && (paddr_in[ADDR_W-1:10] == 2'h0);

  // Byte lanes that reach the 16-bit registers
  assign lane_mask   = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};

  // Address map check
  always_comb
  begin
    mapped = 1'b0;
    if (aligned)
    begin
      unique case (reg_idx)
        IDX_EXPANSION,
        IDX_NP_TX,
        IDX_NP_RX,
        IDX_IRQ_STATUS,
        IDX_IRQ_MASK: mapped = 1'b1;
        default:      mapped = 1'b0;
      endcase
    end
  end

  // Expansion status word; reserved bits read zero
  always_comb
  begin
    exp_word                  = '0;
    exp_word[EXP_PD_FAULT]    = exp_flags.q[EVT_PD_FAULT];
    exp_word[EXP_LP_NP_ABLE]  = lp_np_able_in;
    exp_word[EXP_LOC_NP_ABLE] = LOCAL_NP_ABLE;
    exp_word[EXP_PAGE_RX]     = exp_flags.q[EVT_PAGE_RX];
    exp_word[EXP_LP_AN_ABLE]  = lp_an_able_in;
  end

  // Read data multiplexer; upper bits read zero
  always_comb
  begin
    rd_word = '0;
    if (aligned)
    begin
      unique case (reg_idx)
        IDX_EXPANSION:  rd_word[REG_W-1:0] = exp_word;
        IDX_NP_TX:      rd_word[REG_W-1:0] = cur_r.tx_page;
        IDX_NP_RX:      rd_word[REG_W-1:0] = rx_page;
        IDX_IRQ_STATUS: rd_word[N_EVT-1:0] = irq_flags.q;
        IDX_IRQ_MASK:   rd_word[N_EVT-1:0] = cur_r.irq_mask;
        default:        rd_word = '0;
      endcase
    end
  end

  // Read clears only the flag bits that were actually reported
  always_comb
  begin
    exp_clr = '0;
    if (rd_done && aligned && (reg_idx == IDX_EXPANSION))
    begin
      exp_clr[EVT_PD_FAULT] = cur_r.prdata[EXP_PD_FAULT];
      exp_clr[EVT_PAGE_RX]  = cur_r.prdata[EXP_PAGE_RX];
    end
  end

  // Write of ones clears interrupt status bits
  always_comb
  begin
    irq_clr = '0;
    if (wr_done && aligned && (reg_idx == IDX_IRQ_STATUS) && pstrb_in[0])
      irq_clr = pwdata_in[N_EVT-1:0];
  end

  // Next state of the bus answer, registers and outputs
  always_comb
  begin
    cur_nxt = cur_r;

    // Answer is prepared in the setup cycle, shown in the access cycle
    cur_nxt.pready = setup_phase;
    if (setup_phase)
    begin
      cur_nxt.pslverr = ~mapped;
      cur_nxt.prdata  = pwrite_in ? '0 : rd_word;
    end
    else if (access_done)
    begin
      cur_nxt.pslverr = 1'b0;
    end

    // Register writes take effect at the completing access edge
    if (wr_done && aligned)
    begin
      unique case (reg_idx)
        IDX_NP_TX:
        begin
          cur_nxt.np_tx = (cur_r.np_tx & ~(NP_TX_WR_MASK & lane_mask))
                        | (pwdata_in[REG_W-1:0] & NP_TX_WR_MASK & lane_mask);
        end
        IDX_IRQ_MASK:
        begin
          if (pstrb_in[0])
            cur_nxt.irq_mask = pwdata_in[N_EVT-1:0];
        end
        default:
        begin
          cur_nxt.np_tx = cur_r.np_tx;
        end
      endcase
    end

    // Outgoing next page: message bit tells how the code is read
    cur_nxt.tx_page               = '0;
    cur_nxt.tx_page[NP_NEXT]      = cur_r.np_tx[NP_NEXT];
    cur_nxt.tx_page[NP_ACK]       = 1'b0;
    cur_nxt.tx_page[NP_MSG]       = cur_r.np_tx[NP_MSG];
    cur_nxt.tx_page[NP_ACK2]      = cur_r.np_tx[NP_ACK2];
    cur_nxt.tx_page[NP_TOGGLE]    = toggle;
    cur_nxt.tx_page[NP_CODE_MSB:0] = cur_r.np_tx[NP_CODE_MSB:0];

    // Level interrupt from unmasked status
    cur_nxt.irq = |(irq_flags.q & cur_r.irq_mask);
  end

  // State register
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      cur_r.pready   <= 1'b0;
      cur_r.pslverr  <= 1'b0;
      cur_r.prdata   <= '0;
      cur_r.np_tx    <= NP_TX_RST;
      cur_r.irq_mask <= IRQ_MASK_RST;
      cur_r.irq      <= 1'b0;
      cur_r.tx_page  <= NP_TX_RST;
    end
    else
    begin
      cur_r <= cur_nxt;
    end
  end

  // Outputs straight from the state register
  assign prdata_out  = cur_r.prdata;
  assign pready_out  = cur_r.pready;
  assign pslverr_out = cur_r.pslverr;
  assign irq_out     = cur_r.irq;
  assign tx_page_out = cur_r.tx_page;

endmodule : autoneg_next_page_regs
`default_nettype wire

// ---- autoneg_next_page_regs_bench.sv ----
// Self-checking bench for the next-page register bank
`timescale 1ns/1ns
`default_nettype none
module autoneg_next_page_regs_bench
  import autoneg_np_pkg::*;
;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, er;
  logic        page_rx, pd_fault, lp_np, lp_an, restart;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, strb;
  logic [15:0] rx_page, tx_page;
  logic [31:0] vals [2] = '{32'hffff_ffff, 32'h0000_0123};
  int          mismatches, samples_checked;

  autoneg_next_page_regs u_dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .irq_out(irq), .pd_fault_in(pd_fault), .page_rx_in(page_rx), .rx_page_in(rx_page),
    .lp_np_able_in(lp_np), .lp_an_able_in(lp_an), .an_restart_in(restart), .tx_page_out(tx_page));

  link_partner_model u_lp (.clk_in(sys_clk), .page_rx_out(page_rx), .rx_page_out(rx_page),
    .pd_fault_out(pd_fault), .np_able_out(lp_np), .an_able_out(lp_an), .restart_out(restart));

  // 20 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One APB transfer, held until ready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Ready is looked at where it is settled, ahead of the edge that ends the access
    @(negedge sys_clk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 16)
    begin
      mismatches++;
      wrap_up();
    end
    else
    begin
      rd = prdata;
      er = pslverr;
      @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : xfer

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask : rchk

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    strb = 4'hf;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk("expansion", 12'h018, 32'h4);
    rchk("tx page", 12'h01c, 32'h2001);
    rchk("rx page", 12'h020, 32'h0);
    foreach (vals[i])
    begin
      rchk("unmapped", i ? 12'h019 : 12'h024, 32'h0);
      chk("slverr", 32'h1, {31'h0, er});
      xfer(1'b1, i ? 12'h020 : 12'h018, 32'hffff);
      xfer(1'b1, 12'h01c, vals[i]);
      rchk("tx page", 12'h01c, vals[i] & 32'hb7ff);
      @(negedge sys_clk);
      chk("tx pins", vals[i] & 32'hb7ff, {16'h0, tx_page});
    end
    rchk("expansion", 12'h018, 32'h4);
    rchk("rx page", 12'h020, 32'h0);
    // Low byte lane only reaches the low half of the transmit page
    xfer(1'b1, 12'h01c, 32'h2001);
    strb = 4'h1;
    xfer(1'b1, 12'h01c, 32'hffff);
    strb = 4'hf;
    rchk("tx strobe", 12'h01c, 32'h20ff);
    xfer(1'b1, 12'h01c, 32'h2001);
    for (int i = 0; i < 4; i++)
    begin
      u_lp.set_able(i[1], i[0]);
      rchk("abilities", 12'h018, {28'h0, i[1], 2'b10, i[0]});
    end
    xfer(1'b1, 12'h044, 32'h3);
    u_lp.send_page(16'hc5a5);
    rchk("expansion", 12'h018, 32'hf);
    @(negedge sys_clk);
    chk("irq", 32'h1, {31'h0, irq});
    chk("toggle", 32'h2801, {16'h0, tx_page});
    rchk("expansion", 12'h018, 32'hd);
    rchk("rx page", 12'h020, 32'hc5a5);
    rchk("irq status", 12'h040, 32'h1);
    xfer(1'b1, 12'h040, 32'h1);
    repeat (2) @(negedge sys_clk);
    chk("irq", 32'h0, {31'h0, irq});
    xfer(1'b1, 12'h044, 32'h2);
    u_lp.send_page(16'h0123);
    repeat (3) @(negedge sys_clk);
    chk("irq", 32'h0, {31'h0, irq});
    chk("toggle", 32'h2001, {16'h0, tx_page});
    u_lp.pulse(1'b1);
    rchk("expansion", 12'h018, 32'h1f);
    @(negedge sys_clk);
    chk("irq", 32'h1, {31'h0, irq});
    rchk("expansion", 12'h018, 32'hd);
    u_lp.send_page(16'h8001);
    repeat (2) @(negedge sys_clk);
    chk("toggle", 32'h2801, {16'h0, tx_page});
    u_lp.pulse(1'b0);
    repeat (3) @(negedge sys_clk);
    chk("restart", 32'h2001, {16'h0, tx_page});
    // Reset in mid-run drops flags, toggle and captured page
    u_lp.send_page(16'h4321);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk("tx page", 12'h01c, 32'h2001);
    rchk("expansion", 12'h018, 32'hd);
    rchk("rx page", 12'h020, 32'h0);
    wrap_up();
  end
endmodule : autoneg_next_page_regs_bench
`default_nettype wire

// ---- autoneg_np_pkg.sv ----
// Constants shared by the auto-negotiation next-page register block
package autoneg_np_pkg;

  // Clock rate of sys_clk_in
  localparam int unsigned CLK_HZ          = 20_000_000;

  // APB geometry
  localparam int unsigned ADDR_W          = 12;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned REG_W           = 16;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_EXPANSION   = 8'h06;
  localparam logic [7:0]  IDX_NP_TX       = 8'h07;
  localparam logic [7:0]  IDX_NP_RX       = 8'h08;
  localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h10;
  localparam logic [7:0]  IDX_IRQ_MASK    = 8'h11;

  // Values after reset
  localparam logic [15:0] EXP_RST         = 16'h0004;
  localparam logic [15:0] NP_TX_RST       = 16'h2001;
  localparam logic [15:0] NP_RX_RST       = 16'h0000;
  localparam logic [1:0]  IRQ_MASK_RST    = 2'h0;
  localparam logic        TOGGLE_RST      = 1'b0;
  localparam logic        LOCAL_NP_ABLE   = 1'b1;

  // Expansion status field positions
  localparam int unsigned EXP_PD_FAULT    = 4;
  localparam int unsigned EXP_LP_NP_ABLE  = 3;
  localparam int unsigned EXP_LOC_NP_ABLE = 2;
  localparam int unsigned EXP_PAGE_RX     = 1;
  localparam int unsigned EXP_LP_AN_ABLE  = 0;

  // Next-page word field positions
  localparam int unsigned NP_NEXT         = 15;
  localparam int unsigned NP_ACK          = 14;
  localparam int unsigned NP_MSG          = 13;
  localparam int unsigned NP_ACK2         = 12;
  localparam int unsigned NP_TOGGLE       = 11;
  localparam int unsigned NP_CODE_MSB     = 10;

  // Software-writable bits of the transmit next page
  localparam logic [15:0] NP_TX_WR_MASK   = 16'hb7ff;
  // Null message code
  localparam logic [10:0] NP_CODE_NULL    = 11'h001;

  // Event numbering in the sticky flag vectors
  localparam int unsigned N_EVT           = 2;
  localparam int unsigned EVT_PAGE_RX     = 0;
  localparam int unsigned EVT_PD_FAULT    = 1;

endpackage : autoneg_np_pkg

// ---- autoneg_np_properties.sv ----
// Port checker for the next-page register bank
`timescale 1ns/1ns
`default_nettype none
module autoneg_np_properties
  import autoneg_np_pkg::*;
(
  input wire logic              sys_clk_in,
  input wire logic              rst_n_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [DATA_W-1:0] prdata_out,
  input wire logic              pready_out,
  input wire logic              pslverr_out,
  input wire logic              page_rx_in,
  input wire logic [15:0]       rx_page_in,
  input wire logic              pd_fault_in,
  input wire logic              lp_np_able_in,
  input wire logic              lp_an_able_in,
  input wire logic              an_restart_in,
  input wire logic [15:0]       tx_page_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  logic [15:0] last_page_r;

  // Last page word taken from the partner
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      last_page_r <= 16'h0000;
    else if (page_rx_in)
      last_page_r <= rx_page_in;
  end

  // Setup phase, and setup of a read at one address
  sequence s_setup; psel_in && !penable_in; endsequence
  sequence s_rd(a); s_setup ##0 (!pwrite_in && paddr_in == a); endsequence

  property p_ready; s_setup |=> pready_out ##1 !pready_out; endproperty
  a_ready: assert property (p_ready) else $error("ready not one cycle after setup");
  property p_err; pslverr_out |-> pready_out; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_exp_fixed; s_rd(12'h018) |=> prdata_out[31:5] == 27'h0 && prdata_out[2]; endproperty
  a_exp_fixed: assert property (p_exp_fixed) else $error("expansion fixed bits");
  property p_exp_live;
    s_rd(12'h018) |=> prdata_out[3] == $past(lp_np_able_in) && prdata_out[0] == $past(lp_an_able_in);
  endproperty
  a_exp_live: assert property (p_exp_live) else $error("partner ability bits");
  property p_page_flag; page_rx_in ##2 s_rd(12'h018) |=> prdata_out[1]; endproperty
  a_page_flag: assert property (p_page_flag) else $error("page flag not set");
  property p_fault_flag; pd_fault_in ##2 s_rd(12'h018) |=> prdata_out[4]; endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("fault flag not set");
  property p_rx_cap; s_rd(12'h020) |=> prdata_out == {16'h0, $past(last_page_r)}; endproperty
  a_rx_cap: assert property (p_rx_cap) else $error("received page");
  property p_toggle;
    page_rx_in && !an_restart_in |-> ##2 tx_page_out[11] != $past(tx_page_out[11]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle not inverted");
  property p_restart; an_restart_in |-> ##2 !tx_page_out[11]; endproperty
  a_restart: assert property (p_restart) else $error("toggle not cleared");
  property p_tx_rsv; tx_page_out[14] == 1'b0; endproperty
  a_tx_rsv: assert property (p_tx_rsv) else $error("reserved transmit bit");
  property p_tx_rst; $rose(rst_n_in) |-> tx_page_out == 16'h2001; endproperty
  a_tx_rst: assert property (p_tx_rst) else $error("transmit reset value");
endmodule : autoneg_np_properties

bind autoneg_next_page_regs autoneg_np_properties u_props
(
  .sys_clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out, .pready_out,
  .pslverr_out, .page_rx_in, .rx_page_in, .pd_fault_in, .lp_np_able_in, .lp_an_able_in,
  .an_restart_in, .tx_page_out
);
`default_nettype wire

// ---- flag_if.sv ----
// Set, clear and state signals of a bank of sticky flags
`timescale 1ns/1ns
`default_nettype none
interface flag_if #(parameter int unsigned W = 2);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] q;

  // Owner keeps the flags, user raises and clears them
  modport owner (input set, input clr, output q);
  modport user  (output set, output clr, input q);
endinterface : flag_if
`default_nettype wire

// ---- link_partner_model.sv ----
// Remote link partner making page, fault and restart events
`timescale 1ns/1ns
`default_nettype none
module link_partner_model
(
  input  wire logic        clk_in,
  output var  logic        page_rx_out,
  output var  logic [15:0] rx_page_out,
  output var  logic        pd_fault_out,
  output var  logic        np_able_out,
  output var  logic        an_able_out,
  output var  logic        restart_out
);
  // Quiet at time zero
  initial
  begin
    page_rx_out = 1'b0;
    rx_page_out = 16'h0000;
    pd_fault_out = 1'b0;
    np_able_out = 1'b0;
    an_able_out = 1'b0;
    restart_out = 1'b0;
  end

  // One page; word is junk outside its strobe
  task automatic send_page(input logic [15:0] w);
    @(posedge clk_in);
    page_rx_out <= 1'b1;
    rx_page_out <= w;
    @(posedge clk_in);
    page_rx_out <= 1'b0;
    rx_page_out <= ~w;
  endtask : send_page

  // Single-cycle fault or restart pulse
  task automatic pulse(input logic is_fault);
    @(posedge clk_in);
    pd_fault_out <= is_fault;
    restart_out <= !is_fault;
    @(posedge clk_in);
    pd_fault_out <= 1'b0;
    restart_out <= 1'b0;
  endtask : pulse

  // Ability levels
  task automatic set_able(input logic np, input logic an);
    @(posedge clk_in);
    np_able_out <= np;
    an_able_out <= an;
  endtask : set_able
endmodule : link_partner_model
`default_nettype wire

// ---- np_exchange.sv ----
// Toggle tracking and capture of the partner's received next page
`timescale 1ns/1ns
`default_nettype none
module np_exchange
  import autoneg_np_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        page_rx_in,
  input  wire logic [15:0] rx_page_in,
  input  wire logic        restart_in,
  output var  logic        toggle_out,
  output var  logic [15:0] rx_page_out
);

  typedef struct packed {
    logic        toggle;
    logic [15:0] rx;
  } xchg_state_s;

  xchg_state_s cur_r;
  xchg_state_s cur_nxt;

  // Flip toggle per exchanged word, capture partner page
  always_comb
  begin
    cur_nxt = cur_r;
    if (restart_in)
      cur_nxt.toggle = TOGGLE_RST;
    else if (page_rx_in)
      cur_nxt.toggle = ~cur_r.toggle;
    // Page is kept even when a restart arrives with it
    if (page_rx_in)
      cur_nxt.rx = rx_page_in;
  end

  // State register
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      cur_r.toggle <= TOGGLE_RST;
      cur_r.rx     <= NP_RX_RST;
    end
    else
      cur_r <= cur_nxt;
  end

  assign toggle_out  = cur_r.toggle;
  assign rx_page_out = cur_r.rx;

endmodule : np_exchange
`default_nettype wire

// ---- sticky_flags.sv ----
// Bank of sticky flags where a set beats a clear in the same cycle
`timescale 1ns/1ns
`default_nettype none
module sticky_flags
  import autoneg_np_pkg::*;
#(
  parameter int unsigned W = 2
)
(
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  flag_if.owner     flags
);

  typedef struct packed {
    logic [W-1:0] q;
  } flag_state_s;

  flag_state_s cur_r;
  flag_state_s cur_nxt;

  // Clear first, then set, so an event is never lost
  always_comb
  begin
    cur_nxt   = cur_r;
    cur_nxt.q = (cur_r.q & ~flags.clr) | flags.set;
  end

  // State register
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      cur_r <= '0;
    else
      cur_r <= cur_nxt;
  end

  assign flags.q = cur_r.q;

endmodule : sticky_flags
`default_nettype wire
